// ---- hdl/rtdcac_pkg.sv ----
// Package of constants, types and helpers for the coefficient and average dictionary block
package rtdcac_pkg;

    // ****************************************
    // Dictionary indices and sub-index counts
    // ****************************************
    localparam logic [15:0] IDX_AVG_MODE   = 16'h2112;
    localparam logic [15:0] IDX_AVG_FACTOR = 16'h2126;
    localparam logic [15:0] IDX_AVG_OFFSET = 16'h2127;
    localparam logic [15:0] IDX_AVG_RESULT = 16'h2130;
    localparam logic [15:0] IDX_CURVE_SEL  = 16'h3000;
    localparam logic [15:0] IDX_CONST_A    = 16'h3010;
    localparam logic [15:0] IDX_CONST_B    = 16'h3020;
    localparam logic [15:0] IDX_CONST_C    = 16'h3030;
    localparam int          NUM_CHAN       = 8;
    localparam int          NUM_AVG        = 3;
    localparam int          BANK_CHAN      = 4;
    localparam logic [7:0]  SUB_COUNT_AVG  = 8'h03;
    localparam logic [7:0]  SUB_COUNT_CHAN = 8'h08;

    // ****************************************
    // Encodings and limits
    // ****************************************
    // Constants are fixed point in units of 1e-5
    localparam logic [15:0]        SEL_USER      = 16'h0000;
    localparam logic [15:0]        SEL_DEFAULT   = 16'h0001;
    localparam logic [15:0]        SEL_MAX       = 16'h0005;
    localparam logic signed [31:0] CONST_LIMIT   = 32'sh000F_1B30;  // 9.9
    localparam logic signed [31:0] CONST_A_DFLT  = 32'sh0005_F6AE;  // 3.90830
    localparam logic signed [31:0] CONST_B_DFLT  = -32'sh0008_CFDC; // -5.77500
    localparam logic signed [31:0] CONST_C_DFLT  = -32'sh0006_61FD; // -4.18301
    // Factor and offset are Q16.16
    localparam logic signed [31:0] FACTOR_LIMIT  = 32'sh03E8_0000;  // 1000.0
    localparam logic signed [31:0] OFFSET_LIMIT  = 32'sh2710_0000;  // 10000.0
    localparam logic signed [31:0] FACTOR_DFLT   = 32'sh0010_0000;  // 16.0
    localparam logic signed [31:0] OFFSET_DFLT   = 32'sh1110_0000;  // 4368.0
    localparam logic [7:0]         MODE_DFLT     = 8'h01;
    localparam logic [7:0]         MODE_MAX      = 8'h01;
    localparam int                 FRAC_BITS     = 16;
    localparam logic signed [47:0] RESULT_MAX    = 48'sh0000_0000_7FFF;
    localparam logic signed [47:0] RESULT_MIN    = -48'sh0000_0000_8000;
    // Ratio in units of 1e-17; term weights follow from constant units
    localparam logic signed [63:0] RATIO_ONE     = 64'sh0163_4578_5D8A_0000;
    localparam logic signed [63:0] WEIGHT_A      = 64'sh0000_0000_3B9A_CA00; // 1e9
    localparam logic signed [63:0] WEIGHT_B      = 64'sh0000_0000_0001_86A0; // 1e5
    localparam logic signed [63:0] C_PIVOT       = 64'sh0000_0000_0000_0064; // 100

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic              write;
        logic [15:0]       index;
        logic [7:0]        sub;
        logic [31:0]       data;
    } rtdcac_req_t;

    typedef struct packed {
        logic              err;
        logic [31:0]       data;
    } rtdcac_rsp_t;

    typedef struct packed {
        logic signed [31:0] temp;
        logic               valid;
    } rtdcac_chan_t;

    typedef struct packed {
        logic signed [31:0] a;
        logic signed [31:0] b;
        logic signed [31:0] c;
    } rtdcac_coef_t;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic rtdcac_in_range(input logic signed [31:0] v,
                                             input logic signed [31:0] lim);
        return (v <= lim) && (v >= -lim);
    endfunction

    function automatic logic signed [15:0] rtdcac_clamp16(input logic signed [47:0] v);
        if (v > RESULT_MAX) begin
            return 16'sh7FFF;
        end else if (v < RESULT_MIN) begin
            return -16'sh8000;
        end
        return v[15:0];
    endfunction

endpackage

// ---- hdl/rtdcac_average.sv ----
// Averaging and scaling of a group of channel temperatures
module rtdcac_average #(
    parameter int N = 4
) (
    input  wire logic                                clk_sys_i, // System clock
    input  wire logic                                rst_n_i,   // Async reset, active low
    input  wire rtdcac_pkg::rtdcac_chan_t [N-1:0]    chan_i,    // Temperatures and validity
    input  wire logic                                enable_i,  // Averaging mode is normal
    input  wire logic signed [31:0]                  factor_i,  // Scaling factor Q16.16
    input  wire logic signed [31:0]                  offset_i,  // Scaling offset Q16.16
    output logic signed [15:0]                       result_o,  // Scaled result
    output logic                                     avail_o    // Result is available
);

    if (N < 1 || N > rtdcac_pkg::NUM_CHAN) begin : g_bad_n
        $error("rtdcac_average: N out of range");
    end

    localparam int CW = $clog2(N + 1);

    // ****************************************
    // Sum and count of valid channels
    // ****************************************
    logic signed [35:0] sum;
    logic [CW-1:0]      cnt;
    logic signed [35:0] avg;
    logic signed [67:0] scaled;
    logic signed [47:0] total;

    always_comb begin
        sum = '0;
        cnt = '0;
        for (int i = 0; i < N; i++) begin
            if (chan_i[i].valid) begin
                sum = sum + 36'(chan_i[i].temp);
                cnt = cnt + CW'(1);
            end
        end
        avg    = (cnt == '0) ? '0 : sum / $signed({1'b0, 35'(cnt)});
        scaled = 68'(avg) * 68'(factor_i);
        total  = 48'(scaled >>> rtdcac_pkg::FRAC_BITS) + 48'(offset_i);
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_o <= '0;
            avail_o  <= 1'b0;
        end else begin
            avail_o <= enable_i && (cnt != '0);
            if (enable_i && (cnt != '0)) begin
                result_o <= rtdcac_pkg::rtdcac_clamp16(total >>> rtdcac_pkg::FRAC_BITS);
            end
        end
    end

endmodule

// ---- hdl/rtdcac_curve_eval.sv ----
// Resistance ratio evaluation from a channel's conversion constants
module rtdcac_curve_eval (
    input  wire logic                       clk_sys_i, // System clock
    input  wire logic                       rst_n_i,   // Async reset, active low
    input  wire rtdcac_pkg::rtdcac_coef_t   coef_i,    // Constants of the chosen channel
    input  wire logic signed [15:0]         temp_i,    // Temperature in whole degrees
    output logic signed [63:0]              ratio_o    // Rt over R0 in units of 1e-17
);

    logic signed [63:0] t;
    logic signed [63:0] term_a;
    logic signed [63:0] term_b;
    logic signed [63:0] term_c;

    always_comb begin
        t      = 64'(temp_i);
        term_a = 64'(coef_i.a) * t * rtdcac_pkg::WEIGHT_A;
        term_b = 64'(coef_i.b) * t * t * rtdcac_pkg::WEIGHT_B;
        // Cubic term only applies below zero degrees
        term_c = (temp_i < 0) ? 64'(coef_i.c) * (t - rtdcac_pkg::C_PIVOT) * t * t * t
                              : '0;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ratio_o <= '0;
        end else begin
            ratio_o <= rtdcac_pkg::RATIO_ONE + term_a + term_b + term_c;
        end
    end

endmodule

// ---- hdl/rtdcac_config.sv ----
// Dictionary entries for curve constants, averaging settings and average results
module rtdcac_config #(
    parameter logic [5*32-1:0] CURVE_A = {5{rtdcac_pkg::CONST_A_DFLT}}, // Codes 5..1
    parameter logic [5*32-1:0] CURVE_B = {5{rtdcac_pkg::CONST_B_DFLT}},
    parameter logic [5*32-1:0] CURVE_C = {5{rtdcac_pkg::CONST_C_DFLT}}
) (
    input  wire logic                                         clk_sys_i,   // System clock
    input  wire logic                                         rst_n_i,     // Async reset, low
    input  wire logic                                         req_valid_i, // Entry access
    input  wire rtdcac_pkg::rtdcac_req_t                      req_i,       // Access details
    output logic                                              rsp_valid_o, // Answer pulse
    output rtdcac_pkg::rtdcac_rsp_t                           rsp_o,       // Answer data
    input  wire rtdcac_pkg::rtdcac_chan_t [rtdcac_pkg::NUM_CHAN-1:0] chan_i, // Channels
    output logic signed [15:0]                                result_o [3], // Averages
    output logic [2:0]                                        avail_o,     // Average ready
    input  wire logic [2:0]                                   eval_chan_i, // Channel to use
    input  wire logic signed [15:0]                           eval_temp_i, // Degrees
    output logic signed [63:0]                                eval_ratio_o // Rt over R0
);

    localparam int NC = rtdcac_pkg::NUM_CHAN;
    localparam int NA = rtdcac_pkg::NUM_AVG;

    // ****************************************
    // Stored entries
    // ****************************************
    logic [15:0]        sel_q  [NC];
    logic signed [31:0] ca_q   [NC];
    logic signed [31:0] cb_q   [NC];
    logic signed [31:0] cc_q   [NC];
    logic [7:0]         mode_q [NA];
    logic signed [31:0] fac_q  [NA];
    logic signed [31:0] off_q  [NA];

    // ****************************************
    // Access decode
    // ****************************************
    logic               known;
    logic               ro;
    logic               bad;
    logic               rd_bad;
    logic [31:0]        rd;
    logic [2:0]         ch;
    logic [1:0]         av;
    logic               sub0;
    logic               sub_ok;
    logic               wr_ok;
    logic signed [31:0] wv;
    logic [15:0]        wsel;

    always_comb begin
        known  = 1'b0;
        ro     = 1'b0;
        bad    = 1'b0;
        rd_bad = 1'b0;
        rd     = '0;
        ch     = 3'(req_i.sub - 8'h01);
        av     = 2'(req_i.sub - 8'h01);
        sub0   = (req_i.sub == 8'h00);
        sub_ok = 1'b0;
        wv     = $signed(req_i.data);
        wsel   = req_i.data[15:0];
        unique case (req_i.index)
            rtdcac_pkg::IDX_AVG_MODE, rtdcac_pkg::IDX_AVG_FACTOR,
            rtdcac_pkg::IDX_AVG_OFFSET, rtdcac_pkg::IDX_AVG_RESULT: begin
                known  = 1'b1;
                sub_ok = sub0 || (req_i.sub <= rtdcac_pkg::SUB_COUNT_AVG);
                if (sub0) begin
                    rd = 32'(rtdcac_pkg::SUB_COUNT_AVG);
                end else if (req_i.index == rtdcac_pkg::IDX_AVG_MODE) begin
                    rd  = 32'(mode_q[av]);
                    bad = req_i.data > 32'(rtdcac_pkg::MODE_MAX);
                end else if (req_i.index == rtdcac_pkg::IDX_AVG_FACTOR) begin
                    rd  = fac_q[av];
                    bad = !rtdcac_pkg::rtdcac_in_range(wv, rtdcac_pkg::FACTOR_LIMIT);
                end else if (req_i.index == rtdcac_pkg::IDX_AVG_OFFSET) begin
                    rd  = off_q[av];
                    bad = !rtdcac_pkg::rtdcac_in_range(wv, rtdcac_pkg::OFFSET_LIMIT);
                end else begin
                    rd = 32'(result_o[av]);
                    ro = 1'b1;
                    // Unavailable average cannot be read
                    rd_bad = !avail_o[av];
                end
            end
            rtdcac_pkg::IDX_CURVE_SEL: begin
                known  = 1'b1;
                sub_ok = sub0 || (req_i.sub <= rtdcac_pkg::SUB_COUNT_CHAN);
                rd     = sub0 ? 32'(rtdcac_pkg::SUB_COUNT_CHAN) : 32'(sel_q[ch]);
                bad    = (req_i.data[31:16] != '0) || (wsel > rtdcac_pkg::SEL_MAX);
            end
            rtdcac_pkg::IDX_CONST_A, rtdcac_pkg::IDX_CONST_B, rtdcac_pkg::IDX_CONST_C: begin
                known  = 1'b1;
                sub_ok = sub0 || (req_i.sub <= rtdcac_pkg::SUB_COUNT_CHAN);
                if (sub0) begin
                    rd = 32'(rtdcac_pkg::SUB_COUNT_CHAN);
                end else begin
                    rd = (req_i.index == rtdcac_pkg::IDX_CONST_A) ? ca_q[ch] :
                         (req_i.index == rtdcac_pkg::IDX_CONST_B) ? cb_q[ch] : cc_q[ch];
                    ro = (sel_q[ch] != rtdcac_pkg::SEL_USER);
                end
                bad = bad || !rtdcac_pkg::rtdcac_in_range(wv, rtdcac_pkg::CONST_LIMIT);
            end
            default: begin
                known = 1'b0;
            end
        endcase
        if (sub0) begin
            ro = 1'b1;
        end
    end

    assign wr_ok = req_valid_i && req_i.write && known && sub_ok && !ro && !bad;

    // ****************************************
    // Curve selector and constants
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NC; i++) begin
                sel_q[i] <= rtdcac_pkg::SEL_DEFAULT;
                ca_q[i]  <= rtdcac_pkg::CONST_A_DFLT;
                cb_q[i]  <= rtdcac_pkg::CONST_B_DFLT;
                cc_q[i]  <= rtdcac_pkg::CONST_C_DFLT;
            end
        end else if (wr_ok) begin
            unique case (req_i.index)
                rtdcac_pkg::IDX_CURVE_SEL: begin
                    sel_q[ch] <= wsel;
                    if (wsel != rtdcac_pkg::SEL_USER) begin
                        ca_q[ch] <= CURVE_A[32*(wsel-16'h0001) +: 32];
                        cb_q[ch] <= CURVE_B[32*(wsel-16'h0001) +: 32];
                        cc_q[ch] <= CURVE_C[32*(wsel-16'h0001) +: 32];
                    end
                end
                rtdcac_pkg::IDX_CONST_A: begin
                    ca_q[ch] <= wv;
                end
                rtdcac_pkg::IDX_CONST_B: begin
                    cb_q[ch] <= wv;
                end
                rtdcac_pkg::IDX_CONST_C: begin
                    cc_q[ch] <= wv;
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // Averaging settings
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NA; i++) begin
                mode_q[i] <= rtdcac_pkg::MODE_DFLT;
                fac_q[i]  <= rtdcac_pkg::FACTOR_DFLT;
                off_q[i]  <= rtdcac_pkg::OFFSET_DFLT;
            end
        end else if (wr_ok) begin
            unique case (req_i.index)
                rtdcac_pkg::IDX_AVG_MODE: begin
                    mode_q[av] <= req_i.data[7:0];
                end
                rtdcac_pkg::IDX_AVG_FACTOR: begin
                    fac_q[av] <= wv;
                end
                rtdcac_pkg::IDX_AVG_OFFSET: begin
                    off_q[av] <= wv;
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // Answer
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rsp_valid_o <= 1'b0;
            rsp_o       <= '0;
        end else begin
            rsp_valid_o <= req_valid_i;
            if (req_valid_i) begin
                rsp_o.err  <= !known || !sub_ok || (req_i.write ? (ro || bad)
                                                                : rd_bad);
                rsp_o.data <= req_i.write ? '0 : rd;
            end
        end
    end

    // ****************************************
    // Averages
    // ****************************************
    rtdcac_average #(.N(rtdcac_pkg::BANK_CHAN)) u_avg_bank1 (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .chan_i    (chan_i[3:0]),
        .enable_i  (mode_q[0] == rtdcac_pkg::MODE_MAX),
        .factor_i  (fac_q[0]),
        .offset_i  (off_q[0]),
        .result_o  (result_o[0]),
        .avail_o   (avail_o[0])
    );

    rtdcac_average #(.N(rtdcac_pkg::BANK_CHAN)) u_avg_bank2 (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .chan_i    (chan_i[7:4]),
        .enable_i  (mode_q[1] == rtdcac_pkg::MODE_MAX),
        .factor_i  (fac_q[1]),
        .offset_i  (off_q[1]),
        .result_o  (result_o[1]),
        .avail_o   (avail_o[1])
    );

    rtdcac_average #(.N(NC)) u_avg_total (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .chan_i    (chan_i),
        .enable_i  (mode_q[2] == rtdcac_pkg::MODE_MAX),
        .factor_i  (fac_q[2]),
        .offset_i  (off_q[2]),
        .result_o  (result_o[2]),
        .avail_o   (avail_o[2])
    );

    // ****************************************
    // Conversion relation for the chosen channel
    // ****************************************
    rtdcac_pkg::rtdcac_coef_t eval_coef;

    assign eval_coef = '{a: ca_q[eval_chan_i], b: cb_q[eval_chan_i], c: cc_q[eval_chan_i]};

    rtdcac_curve_eval u_eval (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .coef_i    (eval_coef),
        .temp_i    (eval_temp_i),
        .ratio_o   (eval_ratio_o)
    );

endmodule

// ---- verification/rtdcac_config_assertions.sv ----
// Checker for the dictionary access block
module rtdcac_chk (
    input wire logic                    clk_sys_i,   // Clock
    input wire logic                    rst_n_i,     // Reset
    input wire logic                    req_valid_i, // Request
    input wire rtdcac_pkg::rtdcac_req_t req_i,       // Request data
    input wire logic                    rsp_valid_o, // Answer
    input wire rtdcac_pkg::rtdcac_rsp_t rsp_o,       // Answer data
    input wire rtdcac_pkg::rtdcac_chan_t [rtdcac_pkg::NUM_CHAN-1:0] chan_i, // Channels
    input wire logic [2:0]              avail_o      // Ready
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    wire logic wr;
    wire logic none1;
    assign wr = req_valid_i && req_i.write;
    assign none1 = !(chan_i[0].valid || chan_i[1].valid || chan_i[2].valid || chan_i[3].valid);
    // ****************************************
    // Properties
    // ****************************************
    property p_answer; req_valid_i |=> rsp_valid_o; endproperty
    a_answer: assert property (p_answer) else $error("answer missing");
    property p_quiet; !req_valid_i |=> !rsp_valid_o; endproperty
    a_quiet: assert property (p_quiet) else $error("answer without request");
    property p_ro; wr && req_i.index == rtdcac_pkg::IDX_AVG_RESULT |=> rsp_o.err; endproperty
    a_ro: assert property (p_ro) else $error("result write accepted");
    property p_sel;
        wr && req_i.index == rtdcac_pkg::IDX_CURVE_SEL && req_i.data > 32'h5 |=> rsp_o.err;
    endproperty
    a_sel: assert property (p_sel) else $error("bad selector accepted");
    property p_sub0; wr && req_i.sub == 8'h00 |=> rsp_o.err; endproperty
    a_sub0: assert property (p_sub0) else $error("count write accepted");
    property p_unav;
        req_valid_i && !req_i.write && req_i.index == rtdcac_pkg::IDX_AVG_RESULT
            && req_i.sub == 8'h01 && !avail_o[0] |=> rsp_o.err;
    endproperty
    a_unav: assert property (p_unav) else $error("unavailable read accepted");
    property p_none; none1 |=> !avail_o[0]; endproperty
    a_none: assert property (p_none) else $error("empty bank available");
    property p_wdata; rsp_valid_o && $past(req_i.write) |-> rsp_o.data == 32'h0; endproperty
    a_wdata: assert property (p_wdata) else $error("write answer data");
    property p_hold; !rsp_valid_o |-> $stable(rsp_o); endproperty
    a_hold: assert property (p_hold) else $error("answer changed");
    c_err: cover property (rsp_valid_o && rsp_o.err);
    c_avail: cover property (avail_o[0] ##1 !avail_o[0]);
    c_wsel: cover property (wr && req_i.index == rtdcac_pkg::IDX_CURVE_SEL ##1 !rsp_o.err);
endmodule
bind rtdcac_config rtdcac_chk rtdcac_chk_i (.clk_sys_i, .rst_n_i, .req_valid_i, .req_i,
    .rsp_valid_o, .rsp_o, .chan_i, .avail_o);

// ---- verification/rtdcac_master.sv ----
// Network master model issuing single dictionary accesses
module rtdcac_master (
    input  wire logic                    clk_sys_i,   // Clock
    output rtdcac_pkg::rtdcac_req_t      req_o,       // Request data
    output logic                         req_valid_o, // Request pulse
    input  wire logic                    rsp_valid_i, // Answer pulse
    input  wire rtdcac_pkg::rtdcac_rsp_t rsp_i        // Answer data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        req_valid_o = 1'b0;
        req_o = '0;
    end
    // One-cycle request, then garbage on the released lines
    task automatic access(input logic w, input logic [15:0] x, input logic [7:0] s,
                          input logic [31:0] d, output logic e, output logic [31:0] q);
        int n;
        e = 1'bx;
        q = 'x;
        @(posedge clk_sys_i);
        req_valid_o <= 1'b1;
        req_o <= '{w, x, s, d};
        @(posedge clk_sys_i);
        req_valid_o <= 1'b0;
        req_o <= '{1'b0, ~x, ~s, ~d};
        for (n = 0; n < 4; n++) begin
            @(posedge clk_sys_i);
            if (rsp_valid_i === 1'b1) begin
                e = rsp_i.err;
                q = rsp_i.data;
                break;
            end
        end
    endtask
endmodule

// ---- verification/tb_top.sv ----
// Testbench for the dictionary access block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [159:0] CA = {{3{rtdcac_pkg::CONST_A_DFLT}}, 32'h0001_2345,
                                   rtdcac_pkg::CONST_A_DFLT};
    localparam logic [32:0] ERR = 33'h1_0000_0000;
    logic                           clk_sys_i, rst_n_i, req_valid_i, rsp_valid_o, e;
    rtdcac_pkg::rtdcac_req_t        req_i;
    rtdcac_pkg::rtdcac_rsp_t        rsp_o;
    rtdcac_pkg::rtdcac_chan_t [7:0] chan_i;
    logic signed [15:0]             result_o [3];
    logic signed [15:0]             eval_temp_i;
    logic signed [63:0]             eval_ratio_o;
    logic [2:0]                     avail_o, eval_chan_i;
    logic [31:0]                    q;
    int                             mismatches, comparisons, cycles;
    rtdcac_config #(.CURVE_A(CA)) rtdcac_config_i (.clk_sys_i, .rst_n_i, .req_valid_i,
        .req_i, .rsp_valid_o, .rsp_o, .chan_i, .result_o, .avail_o, .eval_chan_i,
        .eval_temp_i, .eval_ratio_o);
    rtdcac_master rtdcac_master_i (.clk_sys_i, .req_o(req_i), .req_valid_o(req_valid_i),
        .rsp_valid_i(rsp_valid_o), .rsp_i(rsp_o));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic xact(input logic w, input logic [15:0] x, input logic [7:0] s,
                        input logic [31:0] d, input logic [32:0] exp);
        rtdcac_master_i.access(w, x, s, d, e, q);
        if (exp[32]) check($sformatf("err %h.%h", x, s), 64'(e), 64'h1);
        else check($sformatf("entry %h.%h", x, s), 64'({e, q}), 64'(exp));
    endtask
    task automatic stop_test();
        $display("Counts: comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_defaults();
        for (int i = 1; i <= 8; i++) begin
            xact(0, rtdcac_pkg::IDX_CURVE_SEL, 8'(i), 0, 33'h1);
            xact(0, rtdcac_pkg::IDX_CONST_A, 8'(i), 0, {1'b0, rtdcac_pkg::CONST_A_DFLT});
            xact(0, rtdcac_pkg::IDX_CONST_B, 8'(i), 0, {1'b0, rtdcac_pkg::CONST_B_DFLT});
            xact(0, rtdcac_pkg::IDX_CONST_C, 8'(i), 0, {1'b0, rtdcac_pkg::CONST_C_DFLT});
        end
        xact(0, rtdcac_pkg::IDX_CURVE_SEL, 0, 0, 33'h8);
        xact(0, rtdcac_pkg::IDX_AVG_RESULT, 0, 0, 33'h3);
        $display("defaults done");
    endtask
    task automatic t_coef();
        xact(1, rtdcac_pkg::IDX_CONST_A, 1, 32'h1000, ERR);
        xact(0, rtdcac_pkg::IDX_CONST_A, 1, 0, {1'b0, rtdcac_pkg::CONST_A_DFLT});
        xact(1, rtdcac_pkg::IDX_CURVE_SEL, 1, 32'h6, ERR);
        xact(1, rtdcac_pkg::IDX_CURVE_SEL, 1, 32'h0001_0000, ERR);
        xact(1, rtdcac_pkg::IDX_CURVE_SEL, 0, 32'h8, ERR);
        xact(0, 16'h3040, 1, 0, ERR);
        xact(0, rtdcac_pkg::IDX_CURVE_SEL, 1, 0, 33'h1);
        xact(1, rtdcac_pkg::IDX_CURVE_SEL, 1, 0, 33'h0);
        xact(1, rtdcac_pkg::IDX_CONST_A, 1, 32'h1000, 33'h0);
        xact(0, rtdcac_pkg::IDX_CONST_A, 1, 0, 33'h1000);
        xact(1, rtdcac_pkg::IDX_CONST_A, 1, 32'h000F_1B31, ERR);
        xact(1, rtdcac_pkg::IDX_CONST_B, 1, 32'hFFF0_E4D0, 33'h0);
        xact(1, rtdcac_pkg::IDX_CURVE_SEL, 1, 32'h2, 33'h0);
        xact(0, rtdcac_pkg::IDX_CONST_A, 1, 0, 33'h0001_2345);
        xact(0, rtdcac_pkg::IDX_CONST_B, 1, 0, {1'b0, rtdcac_pkg::CONST_B_DFLT});
        $display("coefficients done");
    endtask
    task automatic t_avg();
        chan_i[0] <= '{32'sh000A_0000, 1'b1};
        chan_i[1] <= '{32'sh0014_0000, 1'b1};
        repeat (2) @(posedge clk_sys_i);
        check("avail", 64'(avail_o), 64'h5);
        check("bank1", 64'(result_o[0]), 64'h1200);
        xact(0, rtdcac_pkg::IDX_AVG_RESULT, 2, 0, ERR);
        xact(1, rtdcac_pkg::IDX_AVG_RESULT, 1, 0, ERR);
        chan_i[6] <= '{32'sh0028_0000, 1'b1};
        repeat (2) @(posedge clk_sys_i);
        check("bank2", 64'(result_o[1]), 64'h1390);
        check("total", 64'(result_o[2]), 64'h1285);
        xact(1, rtdcac_pkg::IDX_AVG_FACTOR, 3, 32'h03E8_0001, ERR);
        xact(1, rtdcac_pkg::IDX_AVG_FACTOR, 3, 32'h03E8_0000, 33'h0);
        xact(1, rtdcac_pkg::IDX_AVG_OFFSET, 3, 32'h2710_0000, 33'h0);
        xact(1, rtdcac_pkg::IDX_AVG_MODE, 1, 0, 33'h0);
        repeat (2) @(posedge clk_sys_i);
        check("clamp", 64'(result_o[2]), 64'h7FFF);
        check("mode", 64'(avail_o), 64'h6);
        xact(0, rtdcac_pkg::IDX_AVG_RESULT, 3, 0, 33'h0_0000_7FFF);
        xact(0, rtdcac_pkg::IDX_AVG_RESULT, 1, 0, ERR);
        $display("averages done");
    endtask
    task automatic t_ratio();
        longint x;
        eval_chan_i <= 3'h1;
        for (longint t = -100; t <= 100; t += 100) begin
            eval_temp_i <= 16'(t);
            repeat (2) @(posedge clk_sys_i);
            x = rtdcac_pkg::RATIO_ONE + rtdcac_pkg::CONST_A_DFLT * rtdcac_pkg::WEIGHT_A * t
                + rtdcac_pkg::CONST_B_DFLT * rtdcac_pkg::WEIGHT_B * t * t;
            if (t < 0) x += rtdcac_pkg::CONST_C_DFLT * (t - 100) * t * t * t;
            check("ratio", eval_ratio_o, x);
        end
        $display("ratio done");
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            stop_test();
        end
    end
    initial begin
        rst_n_i = 1'b0;
        chan_i = '0;
        eval_chan_i = 3'h0;
        eval_temp_i = 16'sh0000;
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        t_defaults();
        t_coef();
        t_avg();
        t_ratio();
        stop_test();
    end
endmodule
